// ==== tsp_peer.sv ====
`timescale 1ns/1ps
module tsp_peer (
	input  wire logic  i_lclk, // free link clock
	input  wire logic  i_sk,   // shift clock wire level
	input  wire logic  i_so,   // device serial out wire level
	output logic       o_sk,   // clock made by the peer
	output logic       o_si,   // data toward the device
	output logic [7:0] o_rx    // byte received
);
	logic [7:0] tx_r = 8'h00;
	logic [3:0] tick_r = 4'h0;
	logic [4:0] edge_r = 5'h00;
	logic       run_r = 1'b0;
	initial begin
		o_sk = 1'b0;
		o_si = 1'b0;
		o_rx = 8'h00;
	end
	task load(input logic [7:0] tx);
		tx_r = tx;
		o_si = tx[7];
		o_rx = 8'h00;
	endtask : load
	task start;
		edge_r = 5'h00;
		run_r = 1'b1;
	endtask : start
	always @(posedge i_sk) begin
		o_rx <= {o_rx[6:0], i_so};
	end
	// past the frame the line keeps toggling, never a stale bit
	always @(negedge i_sk) begin
		tx_r <= {tx_r[6:0], ~tx_r[0]};
		o_si <= tx_r[6];
	end
	// phases of 320 ns, well above what the device can resolve
	always @(posedge i_lclk) begin
		if (run_r) begin
			tick_r <= tick_r + 4'h1;
			if (tick_r == 4'h9) begin
				tick_r <= 4'h0;
				o_sk   <= ~o_sk;
				edge_r <= edge_r + 5'h01;
				run_r  <= (edge_r != 5'h0f);
			end
		end
	end
endmodule : tsp_peer

// ==== tsp_pkg.sv ====
package tsp_pkg;
	// data memory addresses of the port registers
	localparam logic [7:0] ADDR_PIN_CFG  = 8'hd5;
	localparam logic [7:0] ADDR_SHIFT    = 8'he9;
	localparam logic [7:0] ADDR_CTRL     = 8'hee;
	localparam logic [7:0] ADDR_STATUS   = 8'hef;

	// field positions
	localparam int CTL_RATE_LO  = 0;
	localparam int CTL_RATE_HI  = 1;
	localparam int CTL_PORT_SEL = 3;
	localparam int PSW_IRQ_EN   = 0;
	localparam int PSW_BUSY     = 2;
	localparam int CFG_SO_DRV   = 4;
	localparam int CFG_MASTER   = 5;
	localparam int CFG_PHASE    = 6;

	// reset values
	localparam logic [7:0] RST_PIN_CFG = 8'h00;
	localparam logic [7:0] RST_SHIFT   = 8'h00;
	localparam logic [7:0] RST_CTRL    = 8'h00;
	localparam logic [7:0] RST_STATUS  = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	// shift length and timing
	localparam logic [3:0] SHIFT_BITS = 4'h8;
	localparam int CLK_NS    = 50;
	localparam int TC_NS     = 1000;
	localparam int TC_CLKS   = (TC_NS + CLK_NS - 1) / CLK_NS;
	localparam int RATE_TC_A = 2;
	localparam int RATE_TC_B = 4;
	localparam int RATE_TC_C = 8;
	localparam logic [6:0] HALF_A = 7'(RATE_TC_A * TC_CLKS / 2);
	localparam logic [6:0] HALF_B = 7'(RATE_TC_B * TC_CLKS / 2);
	localparam logic [6:0] HALF_C = 7'(RATE_TC_C * TC_CLKS / 2);

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} tsp_bus_s;

	typedef struct packed {
		logic o;
		logic oe;
	} tsp_pin_s;
endpackage : tsp_pkg

// ==== tsp_serial_port.sv ====
`timescale 1ns/1ps
// Overview of operation
// (R1) one 8-bit shift register between serial in, serial out and shift clock pins
// (R2) internal shift clock means master, external shift clock means slave
// (R3) port and pin routing work only while the port select bit is one
// (R4) master clock period: 00 gives 2 cycles, 01 gives 4, 1x gives 8
// (R5) setting busy starts shifting; hardware clears busy after eight bits
// (R6) software clearing busy early stops shifting with fewer than eight bits
// (R7) interrupt request on completion of eight bits when enabled
// (R8) software loads the shift register only while the shift clock is low
// (R9) shift clock idles low whenever not shifting, in both phase modes
// (R10) slave software sets busy only while incoming shift clock is low
// (R11) master generates the clock and starts transfers; slave never initiates
// (R12) pin4 bit drives serial out or floats; pin5 bit selects master or slave
// (R13) slave software sets busy on entry; busy clears after eight pulses
// (R14) normal phase: sample on rising edge, shift and drive on falling edge
// (R15) alternate phase: register advances on the rising edge instead
// (R16) phase select is pin6 bit; clear normal, set alternate, reset clear
// (R17) registers at E9 shift, EE control, EF status, D5 pin config
// (R18) most significant bit out first, input enters least significant bit
module tsp_serial_port
	import tsp_pkg::*;
(
	input  wire logic              i_clk,    // system clock, 20 mhz
	input  wire logic              i_rst,    // async reset, active high
	input  wire tsp_pkg::tsp_bus_s i_bus,    // data memory access
	output logic [7:0]             o_rdata,  // read data, registered
	input  wire logic              i_si,     // serial data in pin
	input  wire logic              i_sk_clk, // shift clock pin level, link clock
	output tsp_pkg::tsp_pin_s      o_sk,     // shift clock pin drive
	output tsp_pkg::tsp_pin_s      o_so,     // serial data out pin drive
	output logic                   o_irq     // completion pulse
);
	import tsp_pkg::*;

	typedef struct packed {
		logic [7:0] serial_shift_data;    // [R1]
		logic [7:0] cfg;
		logic [7:0] ctl;
		logic [7:0] processor_status_word;
		logic [3:0] bitcnt;
		logic [6:0] div;
		logic       sk;
		logic       smp;
		logic       irq;
		logic [7:0] rdata;
		logic       si_s1;
		logic       si_s2;
		logic       rt_s1;
		logic       rt_s2;
		logic       rt_d;
		logic       ft_s1;
		logic       ft_s2;
		logic       ft_d;
		logic       sir_s1;
		logic       sir_s2;
		logic       sif_s1;
		logic       sif_s2;
	} tsp_state_s;

	tsp_state_s s_r;
	tsp_state_s s_nxt;

	// link domain: flops on the external shift clock edges
	logic rise_tog_r;
	logic fall_tog_r;
	logic si_rise_r;
	logic si_fall_r;

	function automatic logic [6:0] tsp_half(input logic [7:0] ctl);
		if (ctl[CTL_RATE_HI])
			return HALF_C;
		else if (ctl[CTL_RATE_LO])
			return HALF_B;
		else
			return HALF_A;
	endfunction : tsp_half

	// the link flops only see edges during a frame; each edge becomes a toggle
	// no reset bridge needed: the pin stays low and quiet while reset is held
	always_ff @(posedge i_sk_clk or posedge i_rst) begin
		if (i_rst) begin
			rise_tog_r <= 1'b0;
			si_rise_r  <= 1'b0;
		end else begin
			rise_tog_r <= ~rise_tog_r;
			si_rise_r  <= i_si;
		end
	end

	always_ff @(negedge i_sk_clk or posedge i_rst) begin
		if (i_rst) begin
			fall_tog_r <= 1'b0;
			si_fall_r  <= 1'b0;
		end else begin
			fall_tog_r <= ~fall_tog_r;
			si_fall_r  <= i_si;
		end
	end

	logic       active;
	logic       master;
	logic       alt;
	logic       rise_ev;
	logic       fall_ev;
	logic       rise_bit;
	logic       fall_bit;
	logic       finish;
	logic [3:0] cnt_new;
	logic       wr_psw;
	logic       wr_sio;

	always_comb begin
		s_nxt    = s_r;
		rise_ev  = 1'b0;
		fall_ev  = 1'b0;
		finish   = 1'b0;
		cnt_new  = s_r.bitcnt;
		// data of an edge travels the same two flops as its toggle
		s_nxt.si_s1  = i_si;
		s_nxt.si_s2  = s_r.si_s1;
		s_nxt.rt_s1  = rise_tog_r;
		s_nxt.rt_s2  = s_r.rt_s1;
		s_nxt.rt_d   = s_r.rt_s2;
		s_nxt.ft_s1  = fall_tog_r;
		s_nxt.ft_s2  = s_r.ft_s1;
		s_nxt.ft_d   = s_r.ft_s2;
		s_nxt.sir_s1 = si_rise_r;
		s_nxt.sir_s2 = s_r.sir_s1;
		s_nxt.sif_s1 = si_fall_r;
		s_nxt.sif_s2 = s_r.sif_s1;
		s_nxt.irq    = 1'b0;

		master   = s_r.cfg[CFG_MASTER];                          // [R2] [R12]
		alt      = s_r.cfg[CFG_PHASE];                           // [R16]
		active   = s_r.ctl[CTL_PORT_SEL] && s_r.processor_status_word[PSW_BUSY];   // [R3] [R5]
		rise_bit = master ? s_r.si_s2 : s_r.sir_s2;
		fall_bit = master ? s_r.si_s2 : s_r.sif_s2;
		wr_psw   = i_bus.wr && (i_bus.addr == ADDR_STATUS);
		wr_sio   = i_bus.wr && (i_bus.addr == ADDR_SHIFT);

		if (!active) begin
			s_nxt.sk  = 1'b0;                                    // [R9]
			s_nxt.div = '0;
		end else if (master) begin
			// master makes the clock from the instruction cycle rate
			if (s_r.div == tsp_half(s_r.ctl) - 7'h01) begin     // [R4] [R11]
				s_nxt.div = '0;
				s_nxt.sk  = ~s_r.sk;
				rise_ev   = ~s_r.sk;
				fall_ev   = s_r.sk;
			end else begin
				s_nxt.div = s_r.div + 7'h01;
			end
		end else begin
			// slave only follows edges of the outside clock
			// a master clock left high by a mode change must not linger
			s_nxt.sk = 1'b0;                                     // [R9] [R11]
			rise_ev = s_r.rt_s2 != s_r.rt_d;                     // [R2] [R11]
			fall_ev = s_r.ft_s2 != s_r.ft_d;
		end

		if (rise_ev) begin
			if (alt) begin
				s_nxt.serial_shift_data = {s_r.serial_shift_data[6:0], rise_bit};            // [R15] [R18]
				cnt_new   = s_r.bitcnt + 4'h1;
			end else begin
				s_nxt.smp = rise_bit;                            // [R14]
			end
		end
		if (fall_ev) begin
			if (!alt) begin
				s_nxt.serial_shift_data = {s_r.serial_shift_data[6:0], s_r.smp};             // [R14] [R18]
				cnt_new   = s_r.bitcnt + 4'h1;
			end
			// end on a falling edge so the clock is already low
			finish = (cnt_new == SHIFT_BITS);                    // [R5] [R9]
		end
		s_nxt.bitcnt = cnt_new;
		if (finish) begin
			s_nxt.processor_status_word[PSW_BUSY] = 1'b0;                          // [R5] [R13]
			s_nxt.irq           = s_r.processor_status_word[PSW_IRQ_EN];           // [R7]
			s_nxt.sk            = 1'b0;
		end

		// software access last, so a same-cycle write of busy wins
		if (i_bus.wr) begin
			if (i_bus.addr == ADDR_PIN_CFG) begin
				s_nxt.cfg = i_bus.wdata;                         // [R12] [R16]
			end else if (i_bus.addr == ADDR_SHIFT) begin
				s_nxt.serial_shift_data = i_bus.wdata;                         // [R8]
			end else if (i_bus.addr == ADDR_CTRL) begin
				s_nxt.ctl = i_bus.wdata;                         // [R3] [R4]
			end else if (i_bus.addr == ADDR_STATUS) begin
				s_nxt.processor_status_word = i_bus.wdata;                         // [R6]
				if (i_bus.wdata[PSW_BUSY] && !s_r.processor_status_word[PSW_BUSY]) begin
					s_nxt.bitcnt = '0;                           // [R5]
					s_nxt.div    = '0;
					s_nxt.sk     = 1'b0;
				end
			end
		end

		// unmapped addresses read as zero rather than stale data
		if (i_bus.rd) begin
			if (i_bus.addr == ADDR_PIN_CFG)
				s_nxt.rdata = s_r.cfg;                           // [R17]
			else if (i_bus.addr == ADDR_SHIFT)
				s_nxt.rdata = s_r.serial_shift_data;
			else if (i_bus.addr == ADDR_CTRL)
				s_nxt.rdata = s_r.ctl;
			else if (i_bus.addr == ADDR_STATUS)
				s_nxt.rdata = s_r.processor_status_word;
			else
				s_nxt.rdata = RD_UNMAPPED;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_r     <= '0;
			s_r.serial_shift_data <= RST_SHIFT;
			s_r.cfg <= RST_PIN_CFG;                              // [R16]
			s_r.ctl <= RST_CTRL;
			s_r.processor_status_word <= RST_STATUS;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_rdata = s_r.rdata;
	assign o_irq   = s_r.irq;
	assign o_sk.o  = s_r.sk;
	assign o_sk.oe = s_r.ctl[CTL_PORT_SEL] && s_r.cfg[CFG_MASTER]; // [R3] [R12]
	assign o_so.o  = s_r.serial_shift_data[7];                                   // [R18]
	assign o_so.oe = s_r.ctl[CTL_PORT_SEL] && s_r.cfg[CFG_SO_DRV]; // [R3] [R12]

	// helper: how long the shift clock has held its level
	logic [7:0] lvl_len_r;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			lvl_len_r <= 8'h00;
		else if (s_nxt.sk != s_r.sk)
			lvl_len_r <= 8'h00;
		else if (lvl_len_r != 8'hff)
			lvl_len_r <= lvl_len_r + 8'h01;
	end

	default clocking dc @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sk_idle_low_a: assert property (!active && !$past(active) |-> !s_r.sk) // [R9]
		else $error("shift clock not low while idle");

	sk_rate_a: assert property ($fell(s_r.sk) && $past(active) && master && !$past(finish) // [R4]
		|-> $past(lvl_len_r) + 8'h01 == {1'b0, tsp_half(s_r.ctl)})
		else $error("master clock high phase has wrong length");

	busy_done_a: assert property ($fell(s_r.processor_status_word[PSW_BUSY]) && !$past(wr_psw) // [R5]
		|-> s_r.bitcnt == SHIFT_BITS && !s_r.sk)
		else $error("busy cleared by hardware before eight bits");

	early_stop_a: assert property (wr_psw && !i_bus.wdata[PSW_BUSY] // [R6]
		|=> ##1 !s_r.sk && $stable(s_r.bitcnt))
		else $error("shifting continued after busy cleared");

	irq_done_a: assert property (o_irq |-> s_r.bitcnt == SHIFT_BITS // [R7]
		&& $past(s_r.processor_status_word[PSW_IRQ_EN]) && $past(active))
		else $error("interrupt without completed shift");

	pins_off_a: assert property (!s_r.ctl[CTL_PORT_SEL] |-> !o_sk.oe && !o_so.oe) // [R3]
		else $error("pins driven with port deselected");

	slave_no_clk_a: assert property (!s_r.cfg[CFG_MASTER] |=> !s_r.sk) // [R11]
		else $error("slave produced a shift clock");

	shift_msb_a: assert property ($past(active) && s_r.bitcnt == $past(s_r.bitcnt) + 4'h1 // [R18]
		&& !$past(wr_sio) |-> s_r.serial_shift_data[7:1] == $past(s_r.serial_shift_data[6:0]))
		else $error("shift direction wrong");

	normal_fall_a: assert property (active && master && !alt && $rose(s_r.sk) && !$past(wr_sio) // [R14]
		|-> $stable(s_r.serial_shift_data))
		else $error("normal phase shifted on rising edge");

	// phase behaviour
	alt_fall_a: assert property ($past(active) && master && alt && $fell(s_r.sk) && !$past(wr_sio) // [R15]
		|-> $stable(s_r.serial_shift_data))
		else $error("alternate phase shifted on falling edge");

	alt_rise_a: assert property ($past(active) && master && alt && $rose(s_r.sk) // [R15]
		|-> s_r.bitcnt == $past(s_r.bitcnt) + 4'h1)
		else $error("alternate phase missed a rising shift");

	slave_fall_a: assert property ($past(active) && !master && !alt && s_r.bitcnt != $past(s_r.bitcnt) // [R14]
		|-> $past(fall_ev))
		else $error("slave normal phase shifted off a falling edge");

	slave_in_a: assert property ($past(active) && !master && !alt && $past(rise_ev) // [R14]
		|-> s_r.smp == $past(s_r.sir_s2))
		else $error("slave input not sampled at rising edge");

	// start, stop and completion
	start_clear_a: assert property (wr_psw && i_bus.wdata[PSW_BUSY] && !s_r.processor_status_word[PSW_BUSY] // [R5]
		|=> s_r.bitcnt == 4'h0 && !s_r.sk && s_r.processor_status_word[PSW_BUSY])
		else $error("start did not clear the bit count");

	idle_hold_a: assert property (!active && !wr_psw // [R6]
		|=> $stable(s_r.bitcnt))
		else $error("bits counted while not busy");

	irq_off_a: assert property (!s_r.processor_status_word[PSW_IRQ_EN] |=> !o_irq) // [R7]
		else $error("interrupt while disabled");

	done_low_a: assert property (o_irq |-> !s_r.sk) // [R9]
		else $error("shift clock high at completion");

	// register map and write paths
	rd_shift_a: assert property (i_bus.rd && i_bus.addr == ADDR_SHIFT // [R17]
		|=> o_rdata == $past(s_r.serial_shift_data))
		else $error("shift register read wrong");

	rd_status_a: assert property (i_bus.rd && i_bus.addr == ADDR_STATUS // [R17]
		|=> o_rdata == $past(s_r.processor_status_word))
		else $error("status read wrong");

	wr_ctl_a: assert property (i_bus.wr && i_bus.addr == ADDR_CTRL // [R17]
		|=> s_r.ctl == $past(i_bus.wdata))
		else $error("control write lost");

	wr_cfg_a: assert property (i_bus.wr && i_bus.addr == ADDR_PIN_CFG // [R16]
		|=> s_r.cfg == $past(i_bus.wdata))
		else $error("pin config write lost");

	cv_master_done: cover property (o_irq && master && !alt);
	cv_slow_done: cover property (o_irq && s_r.ctl[CTL_RATE_HI]);
	cv_slave_done: cover property (o_irq && !master);
	cv_alt_done: cover property ($fell(s_r.processor_status_word[PSW_BUSY]) && alt);
	cv_early_stop: cover property (wr_psw && !i_bus.wdata[PSW_BUSY] && active && s_r.bitcnt != 4'h0);
endmodule : tsp_serial_port

// ==== tsp_serial_port_bench.sv ====
`timescale 1ns/1ps
module tsp_serial_port_bench;
	import tsp_pkg::*;
	logic       i_clk = 1'b0;
	logic       i_rst = 1'b1;
	logic       lclk = 1'b0;
	tsp_bus_s   i_bus = '0;
	logic [7:0] o_rdata;
	tsp_pin_s   o_sk;
	tsp_pin_s   o_so;
	logic       o_irq;
	logic       peer_sk;
	logic       peer_si;
	logic       sk_wire;
	logic       so_wire;
	logic       so_last = 1'b0;
	logic       sk_q = 1'b0;
	logic [7:0] rx;
	logic [7:0] rd_v;
	int         fails = 0;
	int         total_checks = 0;
	int         cyc = 0;
	int         irqs = 0;
	int         rises = 0;
	int         gap = 0;
	int         per = 0;
	always #25 i_clk = ~i_clk;
	initial begin
		#7;
		forever #16 lclk = ~lclk;
	end
	// a released serial out reads as the inverse of its last level
	assign sk_wire = o_sk.oe ? o_sk.o : peer_sk;
	assign so_wire = o_so.oe ? o_so.o : ~so_last;
	tsp_serial_port u_tsp_serial_port (.i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
		.i_si(peer_si), .i_sk_clk(sk_wire), .o_sk(o_sk), .o_so(o_so), .o_irq(o_irq));
	tsp_peer u_tsp_peer (.i_lclk(lclk), .i_sk(sk_wire), .i_so(so_wire), .o_sk(peer_sk), .o_si(peer_si), .o_rx(rx));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	always @(negedge i_clk) begin
		cyc++;
		gap++;
		irqs += o_irq;
		if (o_so.oe)
			so_last = o_so.o;
		if (o_sk.o && !sk_q) begin
			rises++;
			per = gap;
			gap = 0;
		end
		sk_q = o_sk.o;
		if (cyc == 20000) begin
			fails++;
			give_verdict;
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		i_bus = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(negedge i_clk);
		i_bus.wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(negedge i_clk);
		i_bus.addr = a;
		i_bus.rd = 1'b1;
		@(negedge i_clk);
		i_bus.rd = 1'b0;
		@(negedge i_clk);
		rd_v = o_rdata;
	endtask : rd
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		rd(a);
		chk(rd_v, exp);
	endtask : rchk
	task automatic wait_idle;
		for (int k = 0; k < 1000; k++) begin
			rd(ADDR_STATUS);
			if (rd_v[PSW_BUSY] === 1'b0)
				break;
		end
	endtask : wait_idle
	initial begin
		int n;
		repeat (5) @(negedge i_clk);
		i_rst = 1'b0;
		rchk(ADDR_PIN_CFG, RST_PIN_CFG);
		rchk(ADDR_SHIFT, RST_SHIFT);
		rchk(ADDR_CTRL, RST_CTRL);
		rchk(ADDR_STATUS, RST_STATUS);
		rchk(8'hd4, RD_UNMAPPED);
		wr(ADDR_CTRL, 8'h0b);
		rchk(ADDR_CTRL, 8'h0b);
		wr(ADDR_PIN_CFG, 8'h70);
		rchk(ADDR_PIN_CFG, 8'h70);
		$display("test registers done");
		wr(ADDR_PIN_CFG, 8'h30);
		for (int r = 0; r < 4; r++) begin
			u_tsp_peer.load(8'h3c ^ 8'(r));
			wr(ADDR_CTRL, 8'h08 | 8'(r));
			wr(ADDR_SHIFT, 8'ha5 + 8'(r));
			wr(ADDR_STATUS, 8'h05);
			wait_idle;
			chk(rd_v, 8'h01);
			rchk(ADDR_SHIFT, 8'h3c ^ 8'(r));
			chk(rx, 8'ha5 + 8'(r));
			chk(8'(per), 8'(r == 0 ? 2 * HALF_A : r == 1 ? 2 * HALF_B : 2 * HALF_C));
			chk(8'(irqs), 8'(r + 1));
			chk({7'h0, o_sk.o}, 8'h00);
		end
		$display("test master rates done");
		wr(ADDR_PIN_CFG, 8'h70);
		wr(ADDR_CTRL, 8'h08);
		u_tsp_peer.load(8'hc3);
		wr(ADDR_STATUS, 8'h04);
		wait_idle;
		chk(rd_v, 8'h00);
		rchk(ADDR_SHIFT, 8'hc3);
		chk({7'h0, o_sk.o}, 8'h00);
		chk(8'(irqs), 8'h04);
		wr(ADDR_PIN_CFG, 8'h30);
		$display("test alternate phase done");
		wr(ADDR_CTRL, 8'h0a);
		u_tsp_peer.load(8'hff);
		wr(ADDR_STATUS, 8'h05);
		// between the third and fourth clock rise
		repeat (480) @(negedge i_clk);
		n = rises;
		wr(ADDR_STATUS, 8'h01);
		repeat (300) @(negedge i_clk);
		chk(8'(rises - n), 8'h00);
		chk({7'h0, o_sk.o}, 8'h00);
		chk(8'(irqs), 8'h04);
		rchk(ADDR_STATUS, 8'h01);
		$display("test abort done");
		wr(ADDR_PIN_CFG, 8'h10);
		u_tsp_peer.load(8'h96);
		wr(ADDR_SHIFT, 8'h69);
		wr(ADDR_STATUS, 8'h04);
		u_tsp_peer.start;
		wait_idle;
		rchk(ADDR_SHIFT, 8'h96);
		chk(rx, 8'h69);
		chk({6'h0, o_sk.oe, o_so.oe}, 8'h01);
		chk(8'(rises - n), 8'h00);
		chk(8'(irqs), 8'h04);
		$display("test slave done");
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_PIN_CFG, 8'h30);
		chk({6'h0, o_sk.oe, o_so.oe}, 8'h00);
		wr(ADDR_STATUS, 8'h04);
		repeat (100) @(negedge i_clk);
		chk(8'(rises - n), 8'h00);
		$display("test port select done");
		give_verdict;
	end
endmodule : tsp_serial_port_bench
